/* core/cex_core.sv */
// execution core for logical, branch and stack instruction groups
`timescale 1ns/100ps
module cex_core (
  input  wire logic        clk_sys,   // 50 MHz system clock
  input  wire logic        rst,       // async reset, active high
  input  wire logic [7:0]  mem_rdata, // memory read data
  output logic [15:0]      mem_addr,  // memory address
  output logic [7:0]       mem_wdata, // memory write data
  output logic             mem_rd,    // read strobe, data valid in the same cycle
  output logic             mem_wr,    // write strobe
  output logic [7:0]       acc,       // accumulator
  output logic [7:0]       flags,     // sign zero 0 aux 0 parity 1 carry
  output logic [15:0]      program_counter, // program counter
  output logic [15:0]      stack_pointer,   // stack pointer
  output logic [15:0]      reg_bc,    // register pair b c
  output logic [15:0]      reg_de,    // register pair d e
  output logic [15:0]      reg_hl,    // register pair h l
  output logic             instr_done // pulse at end of instruction
);
`include "cpu_exec_map.svh"
  cex_pkg::cex_state_e state, next_state;
  // local names for the package states
  localparam cex_pkg::cex_state_e CEX_FETCH = cex_pkg::CEX_FETCH, CEX_DECODE = cex_pkg::CEX_DECODE,
    CEX_IMM1 = cex_pkg::CEX_IMM1, CEX_IMM2 = cex_pkg::CEX_IMM2, CEX_WRHI = cex_pkg::CEX_WRHI,
    CEX_WRLO = cex_pkg::CEX_WRLO, CEX_RDLO = cex_pkg::CEX_RDLO, CEX_RDHI = cex_pkg::CEX_RDHI,
    CEX_MEMOP = cex_pkg::CEX_MEMOP, CEX_WAIT = cex_pkg::CEX_WAIT;
  logic [7:0]  opcode, next_opcode, lo_byte, next_lo_byte;
  logic [15:0] next_mem_addr, next_program_counter, next_stack_pointer;
  logic [15:0] next_reg_bc, next_reg_de, next_reg_hl, push_val, next_push_val;
  logic [7:0]  next_mem_wdata, next_acc, next_flags;
  logic        next_mem_rd, next_mem_wr, next_instr_done, taken;
  logic [4:0]  st_cnt, next_st_cnt;
  logic [4:0]  st_total, next_st_total;
  logic        is_pop, next_is_pop;
  logic [1:0]  pair, next_pair;

  cex_cond u_cond (
    .condition_field (opcode[5:3]),
    .flags           (flags),
    .taken           (taken)
  );

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] szp(input logic [7:0] r, input logic ac, input logic cy);
    szp = {r[7], (r == 8'h00), 1'b0, ac, 1'b0, ~^r, 1'b1, cy};
  endfunction

  function automatic logic [15:0] pair_val(input logic [1:0] p, input logic [15:0] bc,
                                           input logic [15:0] de, input logic [15:0] hl,
                                           input logic [7:0] a, input logic [7:0] f);
    unique case (p)
      2'h0: pair_val = bc;
      2'h1: pair_val = de;
      2'h2: pair_val = hl;
      2'h3: pair_val = {a, f};
    endcase
  endfunction

  function automatic logic [7:0] operand(input logic [2:0] s, input logic [15:0] bc,
                                         input logic [15:0] de, input logic [15:0] hl,
                                         input logic [7:0] a);
    unique case (s)
      3'h0: operand = bc[15:8];
      3'h1: operand = bc[7:0];
      3'h2: operand = de[15:8];
      3'h3: operand = de[7:0];
      3'h4: operand = hl[15:8];
      3'h5: operand = hl[7:0];
      3'h6: operand = 8'h00;
      3'h7: operand = a;
    endcase
  endfunction

  // alu for logical group; memory or immediate byte arrives via src
  function automatic logic [15:0] alu(input logic [2:0] op, input logic [7:0] a,
                                      input logic [7:0] src, input logic [7:0] f);
    logic [8:0] d;
    logic [4:0] dl;
    logic [7:0] r;
    d  = {1'b0, a} - {1'b0, src};
    dl = {1'b0, a[3:0]} - {1'b0, src[3:0]};
    r  = 8'h00;
    unique case (op)
      3'h4: begin
        r = a & src;
        alu = {r, szp(r, a[3] | src[3], 1'b0)};
      end
      3'h5: begin
        r = a ^ src;
        alu = {r, szp(r, 1'b0, 1'b0)};
      end
      3'h6: begin
        r = a | src;
        alu = {r, szp(r, 1'b0, 1'b0)};
      end
      3'h7: alu = {a, szp(d[7:0], ~dl[4], d[8])};
      default: alu = {a, f};
    endcase
  endfunction

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [7:0]  t;
    logic        c;
    logic [15:0] res;
    t = acc;
    c = 1'b0;
    res = 16'h0000;
    next_state = state;
    next_opcode = opcode;
    next_lo_byte = lo_byte;
    next_mem_addr = mem_addr;
    next_mem_wdata = mem_wdata;
    next_mem_rd = 1'b0;
    next_mem_wr = 1'b0;
    next_acc = acc;
    next_flags = flags;
    next_program_counter = program_counter;
    next_stack_pointer = stack_pointer;
    next_reg_bc = reg_bc;
    next_reg_de = reg_de;
    next_reg_hl = reg_hl;
    next_push_val = push_val;
    next_instr_done = 1'b0;
    next_st_cnt = st_cnt + 5'd1;
    next_st_total = st_total;
    next_is_pop = is_pop;
    next_pair = pair;
    unique case (state)
      CEX_FETCH: begin
        next_mem_addr = program_counter;
        next_mem_rd = 1'b1;
        next_program_counter = program_counter + 16'h0001;
        next_st_cnt = 5'd2; // fetch and decode are the first two states
        next_state = CEX_DECODE;
      end
      CEX_DECODE: begin
        next_opcode = mem_rdata;
        next_pair = mem_rdata[5:4];
        next_st_total = 5'(`CEX_ST_ONE);
        next_state = CEX_WAIT;
        if (mem_rdata[7:6] == 2'b10) begin
          if (mem_rdata[2:0] == 3'h6) begin
            next_mem_addr = reg_hl;
            next_mem_rd = 1'b1;
            next_st_total = 5'(`CEX_ST_IMM);
            next_state = CEX_MEMOP;
          end else begin
            res = alu(mem_rdata[5:3], acc,
                      operand(mem_rdata[2:0], reg_bc, reg_de, reg_hl, acc), flags);
            next_acc = res[15:8];
            next_flags = res[7:0];
          end
        end else if (mem_rdata == `CEX_OP_COMPARE_IMM || mem_rdata == `CEX_OP_XOR_IMM) begin
          next_mem_addr = program_counter;
          next_mem_rd = 1'b1;
          next_program_counter = program_counter + 16'h0001;
          next_st_total = 5'(`CEX_ST_IMM);
          next_state = CEX_MEMOP;
        end else if (mem_rdata == `CEX_OP_ROT_LEFT) begin
          next_acc = {acc[6:0], acc[7]};
          next_flags[`CEX_FLG_CARRY] = acc[7];
        end else if (mem_rdata == `CEX_OP_RRC) begin
          next_acc = {acc[0], acc[7:1]};
          next_flags[`CEX_FLG_CARRY] = acc[0];
        end else if (mem_rdata == `CEX_OP_RAL) begin
          next_acc = {acc[6:0], flags[`CEX_FLG_CARRY]};
          next_flags[`CEX_FLG_CARRY] = acc[7];
        end else if (mem_rdata == `CEX_OP_ROT_RIGHT_CARRY) begin
          next_acc = {flags[`CEX_FLG_CARRY], acc[7:1]};
          next_flags[`CEX_FLG_CARRY] = acc[0];
        end else if (mem_rdata == `CEX_OP_INV_ACC) begin
          next_acc = ~acc;
        end else if (mem_rdata == `CEX_OP_INV_CARRY) begin
          next_flags[`CEX_FLG_CARRY] = ~flags[`CEX_FLG_CARRY];
        end else if (mem_rdata == `CEX_OP_STC) begin
          next_flags[`CEX_FLG_CARRY] = 1'b1;
        end else if (mem_rdata == `CEX_OP_DEC_ADJ) begin
          t = acc;
          c = flags[`CEX_FLG_CARRY];
          if (acc[3:0] > `CEX_NIB_LIMIT || flags[`CEX_FLG_AUX]) begin
            t = acc + {4'h0, `CEX_BCD_ADJ};
          end
          if (t[7:4] > `CEX_NIB_LIMIT || c) begin
            c = c | (t[7:4] > `CEX_NIB_LIMIT);
            t = t + {`CEX_BCD_ADJ, 4'h0};
          end
          next_acc = t;
          next_flags = szp(t, (acc[3:0] > `CEX_NIB_LIMIT), c);
        end else if (mem_rdata == `CEX_OP_JUMP_HL) begin
          next_program_counter = reg_hl;
          next_st_total = 5'(`CEX_ST_JUMP_HL);
        end else if (mem_rdata[7:6] == 2'b11 && mem_rdata[2:0] == 3'h7) begin
          next_push_val = program_counter;
          next_mem_addr = stack_pointer - 16'h0001;
          next_st_total = 5'(`CEX_ST_RST);
          next_state = CEX_WRHI;
        end else if (mem_rdata[7:6] == 2'b11 && mem_rdata[3:0] == 4'h5) begin
          next_push_val = pair_val(mem_rdata[5:4], reg_bc, reg_de, reg_hl, acc, flags);
          next_mem_addr = stack_pointer - 16'h0001;
          next_st_total = 5'(`CEX_ST_PUSH);
          next_state = CEX_WRHI;
        end else if (mem_rdata[7:6] == 2'b11 && mem_rdata[3:0] == 4'h1) begin
          next_is_pop = 1'b1;
          next_mem_addr = stack_pointer;
          next_mem_rd = 1'b1;
          next_st_total = 5'(`CEX_ST_POP);
          next_state = CEX_RDLO;
        end else if (mem_rdata == `CEX_OP_RETURN) begin
          next_is_pop = 1'b0;
          next_mem_addr = stack_pointer;
          next_mem_rd = 1'b1;
          next_st_total = 5'(`CEX_ST_RETURN);
          next_state = CEX_RDLO;
        end else if (mem_rdata == `CEX_OP_JUMP || mem_rdata == `CEX_OP_CALL
                     || (mem_rdata[7:6] == 2'b11 && (mem_rdata[2:0] == 3'h2 || mem_rdata[2:0] == 3'h4))) begin
          next_mem_addr = program_counter;
          next_mem_rd = 1'b1;
          next_program_counter = program_counter + 16'h0001;
          next_st_total = 5'(`CEX_ST_JUMP);
          next_state = CEX_IMM1;
        end
      end
      CEX_MEMOP: begin
        res = alu((opcode[7:6] == 2'b10) ? opcode[5:3] : (opcode == `CEX_OP_COMPARE_IMM ? 3'h7 : 3'h5),
                  acc, mem_rdata, flags);
        next_acc = res[15:8];
        next_flags = res[7:0];
        next_state = CEX_WAIT;
      end
      CEX_IMM1: begin
        next_lo_byte = mem_rdata;
        next_mem_addr = program_counter;
        next_mem_rd = 1'b1;
        next_program_counter = program_counter + 16'h0001;
        next_state = CEX_IMM2;
      end
      CEX_IMM2: begin
        next_state = CEX_WAIT;
        if (opcode == `CEX_OP_JUMP || (opcode[2:0] == 3'h2 && taken)) begin
          next_program_counter = {mem_rdata, lo_byte};
        end else if (opcode == `CEX_OP_CALL || (opcode[2:0] == 3'h4 && taken)) begin
          next_push_val = program_counter;
          next_lo_byte = lo_byte;
          next_pair = 2'h0;
          next_mem_wdata = mem_rdata;
          next_mem_addr = stack_pointer - 16'h0001;
          next_st_total = 5'(`CEX_ST_CALL);
          next_state = CEX_WRHI;
        end else if (opcode[2:0] == 3'h4) begin
          next_st_total = 5'(`CEX_ST_CCALLN);
        end
      end
      CEX_WRHI: begin
        next_mem_wr = 1'b1;
        next_mem_wdata = push_val[15:8];
        if (opcode[3:0] != 4'h5) next_push_val[15:8] = mem_wdata; // keep call target high
        next_state = CEX_WRLO;
      end
      CEX_WRLO: begin
        next_mem_wr = 1'b1;
        next_mem_addr = stack_pointer - 16'h0002;
        next_mem_wdata = push_val[7:0];
        next_stack_pointer = stack_pointer - 16'h0002;
        if (opcode[2:0] == 3'h7) next_program_counter = {10'h000, opcode[5:3], 3'h0};
        else if (opcode[3:0] != 4'h5) next_program_counter = {push_val[15:8], lo_byte};
        next_state = CEX_WAIT;
      end
      CEX_RDLO: begin
        next_lo_byte = mem_rdata;
        next_mem_addr = stack_pointer + 16'h0001;
        next_mem_rd = 1'b1;
        next_state = CEX_RDHI;
      end
      CEX_RDHI: begin
        next_stack_pointer = stack_pointer + 16'h0002;
        if (!is_pop) next_program_counter = {mem_rdata, lo_byte};
        else begin
          unique case (pair)
            2'h0: next_reg_bc = {mem_rdata, lo_byte};
            2'h1: next_reg_de = {mem_rdata, lo_byte};
            2'h2: next_reg_hl = {mem_rdata, lo_byte};
            2'h3: begin
              next_acc = mem_rdata;
              next_flags = lo_byte;
            end
          endcase
        end
        next_state = CEX_WAIT;
      end
      CEX_WAIT: begin
        if (st_cnt >= st_total) begin
          next_instr_done = 1'b1;
          next_is_pop = 1'b0;
          next_state = CEX_FETCH;
        end
      end
    endcase
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state <= cex_pkg::CEX_FETCH;
      opcode <= 8'h00;
      lo_byte <= 8'h00;
      mem_addr <= 16'h0000;
      mem_wdata <= 8'h00;
      mem_rd <= 1'b0;
      mem_wr <= 1'b0;
      acc <= 8'h00;
      flags <= 8'h02;
      program_counter <= `CEX_PCNT_RESET;
      stack_pointer <= `CEX_STK_RESET;
      reg_bc <= 16'h0000;
      reg_de <= 16'h0000;
      reg_hl <= 16'h0000;
      push_val <= 16'h0000;
      instr_done <= 1'b0;
      st_cnt <= 5'd0;
      st_total <= 5'd0;
      is_pop <= 1'b0;
      pair <= 2'h0;
    end else begin
      state <= next_state;
      opcode <= next_opcode;
      lo_byte <= next_lo_byte;
      mem_addr <= next_mem_addr;
      mem_wdata <= next_mem_wdata;
      mem_rd <= next_mem_rd;
      mem_wr <= next_mem_wr;
      acc <= next_acc;
      flags <= next_flags;
      program_counter <= next_program_counter;
      stack_pointer <= next_stack_pointer;
      reg_bc <= next_reg_bc;
      reg_de <= next_reg_de;
      reg_hl <= next_reg_hl;
      push_val <= next_push_val;
      instr_done <= next_instr_done;
      st_cnt <= next_st_cnt;
      st_total <= next_st_total;
      is_pop <= next_is_pop;
      pair <= next_pair;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_branch_flags: assert property (@(posedge clk_sys) disable iff (rst)
    (state == cex_pkg::CEX_IMM2) |=> $stable(flags)) else $error("branch changed flags");
  a_push_sp_step: assert property (@(posedge clk_sys) disable iff (rst)
    (state == cex_pkg::CEX_WRLO) |=> stack_pointer == $past(stack_pointer) - 16'h0002)
    else $error("push sp step wrong");
  a_pop_sp_step: assert property (@(posedge clk_sys) disable iff (rst)
    (state == cex_pkg::CEX_RDHI) |=> stack_pointer == $past(stack_pointer) + 16'h0002)
    else $error("pop sp step wrong");
  a_hi_before_lo: assert property (@(posedge clk_sys) disable iff (rst)
    (state == cex_pkg::CEX_WRLO) |-> mem_wr && mem_addr == stack_pointer - 16'h0001)
    else $error("high byte not at sp-1");
  a_cma_flags: assert property (@(posedge clk_sys) disable iff (rst)
    (state == cex_pkg::CEX_DECODE && mem_rdata == `CEX_OP_INV_ACC) |=> acc == ~$past(acc) && $stable(flags))
    else $error("invert acc wrong");
  a_cmc_carry: assert property (@(posedge clk_sys) disable iff (rst)
    (state == cex_pkg::CEX_DECODE && mem_rdata == `CEX_OP_INV_CARRY) |=> flags[0] != $past(flags[0]))
    else $error("carry not inverted");
  a_rlc_carry: assert property (@(posedge clk_sys) disable iff (rst)
    (state == cex_pkg::CEX_DECODE && mem_rdata == `CEX_OP_ROT_LEFT) |=> flags[0] == acc[0])
    else $error("rotate carry mismatch");
  a_jump_via_hl_pc: assert property (@(posedge clk_sys) disable iff (rst)
    (state == cex_pkg::CEX_DECODE && mem_rdata == `CEX_OP_JUMP_HL) |=> program_counter == reg_hl)
    else $error("jump via hl wrong");
  c_call: cover property (@(posedge clk_sys) state == cex_pkg::CEX_WRLO);
  c_pop: cover property (@(posedge clk_sys) state == cex_pkg::CEX_RDHI && is_pop);
  c_jump: cover property (@(posedge clk_sys) state == cex_pkg::CEX_IMM2);
endmodule

/* core/cpu_exec_map.svh */
// constants for the branch, logical and stack execution core
`ifndef CPU_EXEC_MAP_SVH
`define CPU_EXEC_MAP_SVH
`define CEX_OP_COMPARE_IMM 8'hFE
`define CEX_OP_ROT_LEFT    8'h07
`define CEX_OP_RRC     8'h0F
`define CEX_OP_RAL     8'h17
`define CEX_OP_ROT_RIGHT_CARRY 8'h1F
`define CEX_OP_DEC_ADJ     8'h27
`define CEX_OP_INV_ACC     8'h2F
`define CEX_OP_STC     8'h37
`define CEX_OP_INV_CARRY   8'h3F
`define CEX_OP_JUMP        8'hC3
`define CEX_OP_RETURN      8'hC9
`define CEX_OP_CALL    8'hCD
`define CEX_OP_XOR_IMM     8'hEE
`define CEX_OP_JUMP_HL     8'hE9
`define CEX_FLG_S      7
`define CEX_FLG_Z      6
`define CEX_FLG_AUX    4
`define CEX_FLG_P      2
`define CEX_FLG_CARRY  0
`define CEX_NIB_LIMIT  4'h9
`define CEX_BCD_ADJ    4'h6
`define CEX_PCNT_RESET 16'h0000
`define CEX_STK_RESET  16'h0000
`define CEX_ST_SHORT   3
`define CEX_ST_JUMP    10
`define CEX_ST_CCALLN  11
`define CEX_ST_CALL    17
`define CEX_ST_RST     11
`define CEX_ST_JUMP_HL 5
`define CEX_ST_PUSH    11
`define CEX_ST_POP     10
`define CEX_ST_RETURN  10
`define CEX_ST_IMM     7
`define CEX_ST_ONE     4
`endif

/* core/cpu_exec_pkg.sv */
// types for the branch, logical and stack execution core
package cex_pkg;
  typedef enum logic [3:0] {
    CEX_FETCH, CEX_DECODE, CEX_IMM1, CEX_IMM2, CEX_WRHI, CEX_WRLO,
    CEX_RDLO, CEX_RDHI, CEX_MEMOP, CEX_WAIT
  } cex_state_e;
  typedef logic [7:0] cex_byte_t;
endpackage

/* core/cex_cond.sv */
// condition field decoder for conditional branches
`timescale 1ns/100ps
module cex_cond (
  input  wire logic [2:0] condition_field, // condition bits from opcode
  input  wire logic [7:0] flags,           // current flag byte
  output logic            taken            // condition holds
);
`include "cpu_exec_map.svh"
  // ---------------------------------------------------------------
  // condition select
  // ---------------------------------------------------------------
  always_comb begin
    unique case (condition_field)
      3'h0: taken = ~flags[`CEX_FLG_Z];
      3'h1: taken = flags[`CEX_FLG_Z];
      3'h2: taken = ~flags[`CEX_FLG_CARRY];
      3'h3: taken = flags[`CEX_FLG_CARRY];
      3'h4: taken = ~flags[`CEX_FLG_P];
      3'h5: taken = flags[`CEX_FLG_P];
      3'h6: taken = ~flags[`CEX_FLG_S];
      3'h7: taken = flags[`CEX_FLG_S];
    endcase
  end
endmodule

/* bench/clbse_mem_model.sv */
// behavioural program and data memory facing the execution core
`timescale 1ns/100ps
module clbse_mem_model (
  input  wire logic        clk_sys,   // system clock
  input  wire logic [15:0] mem_addr,  // address from the core
  input  wire logic [7:0]  mem_wdata, // write data from the core
  input  wire logic        mem_rd,    // read strobe, address already held
  input  wire logic        mem_wr,    // write strobe
  output logic      [7:0]  mem_rdata  // read data to the core
);
  logic [7:0]  mem [0:65535] = '{default: 8'h00};
  logic [23:0] wr_log [$];

  // read data follows the held address, so it is settled before any sampling edge
  assign mem_rdata = mem[mem_addr];

  // one byte per write strobe; every write is logged for the bench
  always @(posedge clk_sys) begin
    if (mem_wr === 1'b1) begin
      mem[mem_addr] <= mem_wdata;
      wr_log.push_back({mem_addr, mem_wdata});
    end
  end
endmodule

/* bench/cpu_logic_branch_stack_exec_tb.sv */
// self-checking bench running a short program through the execution core
`timescale 1ns/100ps
module cpu_logic_branch_stack_exec_tb;
  typedef struct packed {
    logic [7:0]  acc;
    logic [7:0]  flg;
    logic [7:0]  msk;
    logic [15:0] prog_cnt;
    logic [15:0] stk_ptr;
    logic [15:0] hl;
    logic [7:0]  st;
  } clbse_exp_s;

  logic        clk_sys;
  logic        rst;
  logic [7:0]  mem_rdata;
  logic [15:0] mem_addr;
  logic [7:0]  mem_wdata;
  logic        mem_rd;
  logic        mem_wr;
  logic [7:0]  acc;
  logic [7:0]  flags;
  logic [15:0] program_counter;
  logic [15:0] stack_pointer;
  logic [15:0] reg_bc;
  logic [15:0] reg_de;
  logic [15:0] reg_hl;
  logic        instr_done;
  int          error_cnt;
  int          check_count;
  int          idx;
  logic [7:0]  cyc = 8'h00;
  logic [7:0]  last_cyc;
  clbse_exp_s  e;

  // state after each instruction: acc, flags, flag mask, program counter, stack pointer, hl, states
  // aux carry after compare, and or decimal adjust is left open, so it is masked until cleared
  clbse_exp_s exp_tab [0:32] = '{
    '{8'h5a,8'h06,8'hff,16'h0002,16'h0000,16'h0000,8'h00},
    '{8'h5a,8'h07,8'hff,16'h0003,16'h0000,16'h0000,8'h04},
    '{8'h5a,8'h06,8'hff,16'h0004,16'h0000,16'h0000,8'h04},
    '{8'h5a,8'h07,8'hff,16'h0005,16'h0000,16'h0000,8'h04},
    '{8'had,8'h06,8'hff,16'h0006,16'h0000,16'h0000,8'h04},
    '{8'h5b,8'h07,8'hff,16'h0007,16'h0000,16'h0000,8'h04},
    '{8'ha4,8'h07,8'hff,16'h0008,16'h0000,16'h0000,8'h04},
    '{8'ha4,8'h46,8'hef,16'h000a,16'h0000,16'h0000,8'h07},
    '{8'ha4,8'h87,8'hef,16'h000c,16'h0000,16'h0000,8'h07},
    '{8'ha4,8'h87,8'hef,16'h0020,16'h0000,16'h0000,8'h0a},
    '{8'ha4,8'h87,8'hef,16'h0023,16'h0000,16'h0000,8'h0a},
    '{8'ha4,8'h87,8'hef,16'h0040,16'hfffe,16'h0000,8'h11},
    '{8'ha4,8'h87,8'hef,16'h0026,16'h0000,16'h0000,8'h0a},
    '{8'ha4,8'h87,8'hef,16'h0050,16'hfffe,16'h0000,8'h11},
    '{8'ha4,8'h87,8'hef,16'h0038,16'hfffc,16'h0000,8'h0b},
    '{8'ha4,8'h87,8'hef,16'h0039,16'hfffe,16'h0051,8'h0a},
    '{8'ha4,8'h87,8'hef,16'h003a,16'h0000,16'h0051,8'h0a},
    '{8'ha4,8'h87,8'hef,16'h0051,16'h0000,16'h0051,8'h05},
    '{8'ha4,8'h87,8'hef,16'h0054,16'h0000,16'h0051,8'h0b},
    '{8'ha4,8'h87,8'hef,16'h0055,16'hfffe,16'h0051,8'h0b},
    '{8'h00,8'h46,8'hef,16'h0056,16'hfffe,16'h0051,8'h04},
    '{8'h51,8'h02,8'hff,16'h0057,16'hfffe,16'h0051,8'h04},
    '{8'h78,8'h06,8'hff,16'h0058,16'hfffe,16'h0051,8'h04},
    '{8'h9a,8'h86,8'hff,16'h005a,16'hfffe,16'h0051,8'h07},
    '{8'h00,8'h47,8'hef,16'h005b,16'hfffe,16'h0051,8'h04},
    '{8'h00,8'h87,8'hef,16'h005c,16'hfffe,16'h0051,8'h04},
    '{8'h00,8'h87,8'hef,16'h005f,16'hfffe,16'h0051,8'h0a},
    '{8'h00,8'h87,8'hef,16'h0064,16'hfffe,16'h0051,8'h0a},
    '{8'h00,8'h87,8'hef,16'h0067,16'hfffe,16'h0051,8'h0a},
    '{8'h00,8'h87,8'hef,16'h006c,16'hfffe,16'h0051,8'h0a},
    '{8'h00,8'h87,8'hef,16'h006f,16'hfffe,16'h0051,8'h0a},
    '{8'h00,8'h87,8'hef,16'h0074,16'hfffe,16'h0051,8'h0a},
    '{8'h00,8'h87,8'hef,16'h0080,16'hfffe,16'h0051,8'h0a}
  };
  // stack writes in order: address and byte, high byte first
  logic [23:0] wr_exp [0:7] = '{24'hff_ff00, 24'hff_fe26, 24'hff_ff00, 24'hff_fe29,
                                24'hff_fd00, 24'hff_fc51, 24'hff_ff00, 24'hff_fe00};

  cex_core u_dut (
    .clk_sys(clk_sys), .rst(rst), .mem_rdata(mem_rdata), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rd(mem_rd), .mem_wr(mem_wr), .acc(acc), .flags(flags),
    .program_counter(program_counter), .stack_pointer(stack_pointer), .reg_bc(reg_bc),
    .reg_de(reg_de), .reg_hl(reg_hl), .instr_done(instr_done)
  );

  clbse_mem_model u_mem (
    .clk_sys(clk_sys), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rd(mem_rd),
    .mem_wr(mem_wr), .mem_rdata(mem_rdata)
  );

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  // compare one value and count the outcome
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] expd);
    check_count++;
    if (seen !== expd) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, expd, seen);
    end
  endtask

  // place program bytes in memory
  task automatic ld(input logic [15:0] a, input logic [7:0] b [$]);
    foreach (b[i]) u_mem.mem[a + 16'(i)] = b[i];
  endtask

  // print counts and verdict, then stop
  task automatic test_done;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // clock, cycle count and per-instruction checks
  // ----------------------------------------
  always #10 clk_sys = ~clk_sys;

  always @(posedge clk_sys) cyc <= cyc + 8'h01;

  // compare architectural state at each end pulse, and instruction length where the table gives a nonzero state count
  always @(negedge clk_sys) begin
    if (rst === 1'b0 && instr_done === 1'b1 && idx < 33) begin
      e = exp_tab[idx];
      check("acc", {8'h00, acc}, {8'h00, e.acc});
      check("flags", {8'h00, flags & e.msk}, {8'h00, e.flg & e.msk});
      check("program_counter", program_counter, e.prog_cnt);
      check("stack_pointer", stack_pointer, e.stk_ptr);
      check("hl", reg_hl, e.hl);
      if (e.st != 8'h00) check("states", {8'h00, cyc - last_cyc}, {8'h00, e.st});
      last_cyc = cyc;
      idx++;
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    clk_sys = 1'b0;
    rst = 1'b1;
    error_cnt = 0;
    check_count = 0;
    idx = 0;
    last_cyc = 8'h00;
    ld(16'h0000, '{8'hee, 8'h5a, 8'h37, 8'h3f, 8'h37, 8'h1f, 8'h07, 8'h2f, 8'hfe, 8'ha4, 8'hfe, 8'ha5,
                   8'hda, 8'h20, 8'h00});
    ld(16'h0020, '{8'hd2, 8'h00, 8'h00, 8'hcd, 8'h40, 8'h00, 8'hdc, 8'h50, 8'h00});
    ld(16'h0038, '{8'he1, 8'hd1, 8'he9});
    ld(16'h0040, '{8'hc9});
    ld(16'h0050, '{8'hff, 8'hd4, 8'h00, 8'h00, 8'hc5, 8'ha2, 8'hb5, 8'hab, 8'hee, 8'he2, 8'h27, 8'hbd});
    ld(16'h005c, '{8'he2, 8'h00, 8'h00, 8'hea, 8'h64, 8'h00, 8'h00, 8'h00, 8'hf2, 8'h00, 8'h00,
                   8'hfa, 8'h6c, 8'h00, 8'h00, 8'h00, 8'hca, 8'h00, 8'h00, 8'hc2, 8'h74, 8'h00,
                   8'h00, 8'h00, 8'hc3, 8'h80, 8'h00});
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    while (idx < 33) @(posedge clk_sys);
    check("writes", 16'(u_mem.wr_log.size()), 16'h0008);
    foreach (wr_exp[i]) begin
      if (i < u_mem.wr_log.size()) check("write", u_mem.wr_log[i][15:0], wr_exp[i][15:0]);
      if (i < u_mem.wr_log.size()) check("waddr", {8'h00, u_mem.wr_log[i][23:16]}, {8'h00, wr_exp[i][23:16]});
    end
    check("de", reg_de, 16'h0029);
    check("bc", reg_bc, 16'h0000);
    test_done;
  end

  // cut a hang short well beyond the expected run length
  initial begin
    repeat (3000) @(posedge clk_sys);
    error_cnt++;
    test_done;
  end
endmodule
